// >>> inc/pulse_pkg.sv
// Constants, register map and types of the energy pulse output generator.
package pulse_pkg;

	// ------------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------------
	localparam int N_OUT_MAX = 4;
	localparam int N_PHASE = 3;
	localparam int N_TYPE = 4;
	localparam int N_POWER = N_PHASE * N_TYPE;
	localparam int ACC_W = 48;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int SYS_CLK_KHZ = 50000;
	localparam int DIGITAL_TO_FREQ_CONVERTER_KHZ = 4096;
	localparam int PULSE_LONG_MS = 80;
	localparam int LONG_CYCLES_DEF = SYS_CLK_KHZ * PULSE_LONG_MS;
	localparam int THR_SHIFT = 9;
	localparam int DIV_MIN = 2;
	localparam int DIV_MAX = 65535;
	localparam int WIDTH_TIMER_MAX = 327680;

	// ------------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] OFS_GENERAL_CONFIG = 8'h00;
	localparam logic [7:0] OFS_PULSE_MODE = 8'h04;
	localparam logic [7:0] OFS_COMPUTATION_MODE = 8'h08;
	localparam logic [7:0] OFS_WIDTH_CONFIG = 8'h0C;
	localparam logic [7:0] OFS_WIDTH_TIMER = 8'h10;
	localparam logic [7:0] OFS_THRESHOLD = 8'h14;
	localparam logic [7:0] OFS_DIVIDER0 = 8'h18;
	localparam logic [7:0] OFS_PRIMARY_STATUS = 8'h28;
	localparam logic [7:0] OFS_MASK = 8'h2C;
	localparam logic [7:0] OFS_SIGN_REPORT = 8'h30;
	localparam logic [7:0] OFS_EVENT_STATUS = 8'h34;

	// ------------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------------
	localparam int CLR_POS = 0;
	localparam int SEL_W = 3;
	localparam int DIS_POS = 12;
	localparam int READY_POS = 0;
	localparam int SIGNCHG_POS = 4;
	localparam logic [31:0] THRESHOLD_RST = 32'h0000FFFF;
	localparam logic [15:0] DIVIDER_RST = 16'hFFFF;
	localparam logic [19:0] WIDTH_TIMER_RST = 20'h50000;
	localparam logic [11:0] PHASE_SEL_RST = 12'hFFF;

	typedef logic [N_POWER-1:0][31:0] power_bus_t;

endpackage : pulse_pkg

// >>> inc/pulse_chan_if.sv
// Signals between the register block and one pulse output channel.
interface pulse_chan_if;
	import pulse_pkg::*;

	logic tick;
	logic clear;
	logic no_load;
	logic [2:0] type_sel;
	logic [2:0] phase_sel;
	logic disable_out;
	logic width_mode;
	logic [19:0] width_timer;
	logic [31:0] threshold;
	logic [15:0] divider;
	power_bus_t power;
	logic fire_evt;
	logic sign_chg_evt;
	logic sum_sign;
	logic out_high;

	modport ctrl(
		output tick, clear, no_load, type_sel, phase_sel, disable_out,
		output width_mode, width_timer, threshold, divider, power,
		input fire_evt, sign_chg_evt, sum_sign, out_high
	);
	modport chan(
		input tick, clear, no_load, type_sel, phase_sel, disable_out,
		input width_mode, width_timer, threshold, divider, power,
		output fire_evt, sign_chg_evt, sum_sign, out_high
	);

endinterface : pulse_chan_if

// >>> rtl/pulse_channel.sv
// One digital-to-frequency channel: accumulator, divider and pulse shaping.
module pulse_channel
	import pulse_pkg::*;
#(
	parameter int LONG_CYCLES = LONG_CYCLES_DEF
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	pulse_chan_if.chan ch
);

	if (LONG_CYCLES < 1) begin : gen_bad_long
		$error("LONG_CYCLES must be positive.");
	end

	logic signed [ACC_W-1:0] acc_reg;
	logic [15:0] div_cnt_reg;
	logic signed [17:0] net_reg;
	logic have_prev_reg;
	logic prev_sign_reg;
	logic sum_sign_reg;
	logic out_high_reg;
	logic [31:0] long_cnt_reg;
	logic [19:0] wt_cnt_reg;
	logic signed [ACC_W-1:0] sel_sum;
	logic signed [ACC_W-1:0] acc_next;
	logic signed [ACC_W-1:0] thr_ext;
	logic pos_pulse;
	logic neg_pulse;
	logic int_pulse;
	logic fire;
	logic new_sign;
	logic [16:0] half_cnt;
	logic width_done;

	// ------------------------------------------------------------------
	// Selected power
	// ------------------------------------------------------------------
	always_comb begin
		sel_sum = '0;
		for (int p = 0; p < N_PHASE; p++) begin
			if (ch.phase_sel[p] && ch.type_sel < 3'(N_TYPE)) begin //RULE14 RULE15
				sel_sum = sel_sum + ACC_W'(signed'(
					ch.power[int'(ch.type_sel) * N_PHASE + p]));
			end
		end
	end

	// ------------------------------------------------------------------
	// Threshold compare
	// ------------------------------------------------------------------
	assign thr_ext = ACC_W'({ch.threshold, THR_SHIFT'(0)}); //RULE2
	assign acc_next = acc_reg + sel_sum;
	assign pos_pulse = ch.tick && !ch.no_load && acc_next >= thr_ext; //RULE17
	assign neg_pulse = ch.tick && !ch.no_load && acc_next <= -thr_ext;
	assign int_pulse = pos_pulse || neg_pulse;
	assign fire = int_pulse && (div_cnt_reg + 16'h0001 >= ch.divider); //RULE1
	assign new_sign = (net_reg + (pos_pulse ? 18'sh00001 : -18'sh00001))
		< 18'sh00000; //RULE8

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			acc_reg <= '0;
		end else if (ch.clear) begin
			acc_reg <= '0; //RULE10
		end else if (pos_pulse) begin
			acc_reg <= acc_next - thr_ext; //RULE17
		end else if (neg_pulse) begin
			acc_reg <= acc_next + thr_ext;
		end else if (ch.tick && !ch.no_load) begin
			acc_reg <= acc_next;
		end
	end

	// ------------------------------------------------------------------
	// Divider and pulse sign
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			div_cnt_reg <= '0;
			net_reg <= '0;
		end else if (ch.clear) begin
			div_cnt_reg <= '0; //RULE10
			net_reg <= '0;
		end else if (fire) begin
			div_cnt_reg <= '0;
			net_reg <= '0;
		end else if (int_pulse) begin
			div_cnt_reg <= div_cnt_reg + 16'h0001;
			net_reg <= net_reg + (pos_pulse ? 18'sh00001 : -18'sh00001);
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			have_prev_reg <= 1'b0;
			prev_sign_reg <= 1'b0;
			sum_sign_reg <= 1'b0;
		end else if (fire) begin
			have_prev_reg <= 1'b1; //RULE13
			prev_sign_reg <= new_sign;
			sum_sign_reg <= new_sign; //RULE8
		end
	end

	assign ch.fire_evt = fire && !ch.disable_out; //RULE12
	assign ch.sign_chg_evt = fire && have_prev_reg
		&& (new_sign != prev_sign_reg); //RULE9 RULE13
	assign ch.sum_sign = sum_sign_reg;

	// ------------------------------------------------------------------
	// Pulse width
	// ------------------------------------------------------------------
	assign half_cnt = ({1'b0, ch.divider} + 17'h00001) >> 1; //RULE5
	always_comb begin
		if ({1'b0, div_cnt_reg} >= half_cnt) begin
			width_done = 1'b1; //RULE5
		end else if (ch.width_mode) begin
			width_done = wt_cnt_reg >= ch.width_timer; //RULE6
		end else begin
			width_done = long_cnt_reg >= 32'(LONG_CYCLES); //RULE4
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			out_high_reg <= 1'b1; //RULE17
			long_cnt_reg <= '0;
			wt_cnt_reg <= '0;
		end else if (ch.disable_out) begin
			out_high_reg <= 1'b1; //RULE11
		end else if (fire) begin
			out_high_reg <= 1'b0;
			long_cnt_reg <= 32'h00000001;
			wt_cnt_reg <= '0;
		end else if (!out_high_reg) begin
			long_cnt_reg <= long_cnt_reg + 32'h00000001;
			if (ch.tick) begin
				wt_cnt_reg <= wt_cnt_reg + 20'h00001; //RULE6
			end
			if (width_done && !(ch.no_load && ch.width_mode)) begin
				out_high_reg <= 1'b1; //RULE16
			end
		end
	end

	assign ch.out_high = out_high_reg;

endmodule : pulse_channel

// >>> rtl/energy_pulse_output_generator.sv
// Energy pulse output generator: APB registers, interrupt and channels.
//
// Implementation choices: the register addresses and the APB register port.

// Function
// RULE1 - One output pulse per divider internal pulses
// RULE2 - Frequency equals clock times power over threshold
// RULE3 - Software programs threshold to recommended value
// RULE4 - Width mode zero: slow pulses 80 ms low
// RULE5 - Fast pulses: half duty, odd divider rounds up
// RULE6 - Width mode one: low for timer value
// RULE7 - Software keeps width timer within range
// RULE8 - Sign bit reports net energy sign
// RULE9 - Sign change sets flag in both statuses
// RULE10 - Clear bit empties accumulator and divider
// RULE11 - Disabled output stays high
// RULE12 - Disabled output sets no ready status
// RULE13 - Sign change flags ignore disable
// RULE14 - Type select picks energy source
// RULE15 - Phase include picks contributing phases
// RULE16 - No-load: mode one holds low pulse
// RULE17 - Accumulate per tick, keep remainder, idle high
module energy_pulse_output_generator
	import pulse_pkg::*;
#(
	parameter int N_OUT = N_OUT_MAX,
	parameter int LONG_CYCLES = LONG_CYCLES_DEF
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire power_bus_t i_power,
	input wire logic i_no_load,
	output logic [N_OUT-1:0] o_energy_pulse_out_b,
	output logic o_interrupt_out_first
);

	if (N_OUT < 1 || N_OUT > N_OUT_MAX) begin : gen_bad_n_out
		$error("N_OUT must lie between 1 and 4.");
	end
	if (LONG_CYCLES < 1) begin : gen_bad_long
		$error("LONG_CYCLES must be positive.");
	end

	// ------------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------------
	logic rst_meta_reg;
	logic rst_n;

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rst_meta_reg <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n <= rst_meta_reg;
		end
	end

	// ------------------------------------------------------------------
	// Converter clock tick
	// ------------------------------------------------------------------
	logic [15:0] phase_reg;
	logic tick_reg;

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_reg <= '0;
			tick_reg <= 1'b0;
		end else if (phase_reg + 16'(DIGITAL_TO_FREQ_CONVERTER_KHZ) >= 16'(SYS_CLK_KHZ)) begin
			phase_reg <= phase_reg + 16'(DIGITAL_TO_FREQ_CONVERTER_KHZ) - 16'(SYS_CLK_KHZ); //RULE2
			tick_reg <= 1'b1;
		end else begin
			phase_reg <= phase_reg + 16'(DIGITAL_TO_FREQ_CONVERTER_KHZ);
			tick_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	logic clear_reg;
	logic [31:0] pulse_mode_reg;
	logic [11:0] computation_mode_reg;
	logic [3:0] width_config_reg;
	logic [19:0] width_timer_reg;
	logic [31:0] threshold_reg;
	logic [3:0][15:0] divider_reg;
	logic [7:0] primary_status_reg;
	logic [7:0] primary_status_next;
	logic [3:0] event_status_reg;
	logic [3:0] event_status_next;
	logic [7:0] mask_reg;
	logic [3:0] sign_report_reg;
	logic [3:0] fire_vec;
	logic [3:0] chg_vec;
	logic wr_en;
	logic rd_en;
	logic setup_rd;
	logic mapped;
	logic [31:0] rdata;

	assign wr_en = i_psel && i_penable && i_pwrite;
	assign rd_en = i_psel && i_penable && !i_pwrite;
	assign setup_rd = i_psel && !i_penable && !i_pwrite;
	assign o_pready = 1'b1;

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			clear_reg <= 1'b0;
			pulse_mode_reg <= '0;
			computation_mode_reg <= PHASE_SEL_RST;
			width_config_reg <= '0;
			width_timer_reg <= WIDTH_TIMER_RST;
			threshold_reg <= THRESHOLD_RST;
			divider_reg <= {4{DIVIDER_RST}};
			mask_reg <= '0;
		end else begin
			clear_reg <= wr_en && i_paddr == OFS_GENERAL_CONFIG
				&& i_pwdata[CLR_POS]; //RULE10
			if (wr_en) begin
				unique case (i_paddr)
					OFS_PULSE_MODE: pulse_mode_reg <= i_pwdata;
					OFS_COMPUTATION_MODE: computation_mode_reg <= i_pwdata[11:0];
					OFS_WIDTH_CONFIG: width_config_reg <= i_pwdata[3:0];
					OFS_WIDTH_TIMER: width_timer_reg <= i_pwdata[19:0];
					OFS_THRESHOLD: threshold_reg <= i_pwdata;
					OFS_MASK: mask_reg <= i_pwdata[7:0];
					default: begin
					end
				endcase
				for (int i = 0; i < N_OUT_MAX; i++) begin
					if (i_paddr == OFS_DIVIDER0 + 8'(4 * i)
						&& i_pwdata[15:0] >= 16'(DIV_MIN)) begin
						divider_reg[i] <= i_pwdata[15:0]; //RULE1
					end
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Status and interrupt
	// ------------------------------------------------------------------
	always_comb begin
		primary_status_next = primary_status_reg;
		event_status_next = event_status_reg;
		if (rd_en && i_paddr == OFS_PRIMARY_STATUS) begin
			primary_status_next = '0;
		end
		if (rd_en && i_paddr == OFS_EVENT_STATUS) begin
			event_status_next = '0;
		end
		primary_status_next = primary_status_next
			| {chg_vec, fire_vec}; //RULE9 RULE12
		event_status_next = event_status_next | chg_vec; //RULE9
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			primary_status_reg <= '0;
			event_status_reg <= '0;
			o_interrupt_out_first <= 1'b0;
		end else begin
			primary_status_reg <= primary_status_next;
			event_status_reg <= event_status_next;
			o_interrupt_out_first <= |(primary_status_next & mask_reg);
		end
	end

	// ------------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------------
	always_comb begin
		rdata = '0;
		mapped = 1'b1;
		unique case (i_paddr)
			OFS_GENERAL_CONFIG: rdata = '0;
			OFS_PULSE_MODE: rdata = pulse_mode_reg;
			OFS_COMPUTATION_MODE: rdata = {20'h00000, computation_mode_reg};
			OFS_WIDTH_CONFIG: rdata = {28'h0000000, width_config_reg};
			OFS_WIDTH_TIMER: rdata = {12'h000, width_timer_reg};
			OFS_THRESHOLD: rdata = threshold_reg;
			// Status reads return the value that the access phase clears.
			OFS_PRIMARY_STATUS: rdata = {24'h000000, primary_status_next};
			OFS_MASK: rdata = {24'h000000, mask_reg};
			OFS_SIGN_REPORT: rdata = {28'h0000000, sign_report_reg};
			OFS_EVENT_STATUS: rdata = {28'h0000000, event_status_next};
			default: begin
				mapped = 1'b0;
				for (int i = 0; i < N_OUT_MAX; i++) begin
					if (i_paddr == OFS_DIVIDER0 + 8'(4 * i)) begin
						rdata = {16'h0000, divider_reg[i]};
						mapped = 1'b1;
					end
				end
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_prdata <= '0;
			o_pslverr <= 1'b0;
		end else if (i_psel && !i_penable) begin
			o_prdata <= setup_rd ? rdata : 32'h00000000;
			o_pslverr <= !mapped || i_paddr[1:0] != 2'b00;
		end
	end

	// ------------------------------------------------------------------
	// Channels
	// ------------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < N_OUT_MAX; g++) begin : gen_chan
			if (g < N_OUT) begin : gen_used
				pulse_chan_if ch ();

				assign ch.tick = tick_reg;
				assign ch.clear = clear_reg;
				assign ch.no_load = i_no_load;
				assign ch.type_sel = pulse_mode_reg[SEL_W*g +: SEL_W]; //RULE14
				assign ch.phase_sel =
					computation_mode_reg[SEL_W*g +: SEL_W]; //RULE15
				assign ch.disable_out = pulse_mode_reg[DIS_POS + g]; //RULE11
				assign ch.width_mode = width_config_reg[g];
				assign ch.width_timer = width_timer_reg;
				assign ch.threshold = threshold_reg;
				assign ch.divider = divider_reg[g];
				assign ch.power = i_power;
				assign fire_vec[g] = ch.fire_evt;
				assign chg_vec[g] = ch.sign_chg_evt;
				assign sign_report_reg[g] = ch.sum_sign; //RULE8
				assign o_energy_pulse_out_b[g] = ch.out_high;

				pulse_channel #(
					.LONG_CYCLES(LONG_CYCLES)
				) u_chan (
					.i_clk(i_clk),
					.i_rst_n(rst_n),
					.ch(ch)
				);
			end else begin : gen_unused
				assign fire_vec[g] = 1'b0;
				assign chg_vec[g] = 1'b0;
				assign sign_report_reg[g] = 1'b0;
			end
		end
	endgenerate

endmodule : energy_pulse_output_generator

// >>> tb/energy_pulse_monitor.sv
// Port checker of the energy pulse output generator.
module energy_pulse_monitor
	import pulse_pkg::*;
#(
	parameter int N_OUT = N_OUT_MAX
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic i_no_load,
	input wire logic [N_OUT-1:0] o_energy_pulse_out_b,
	input wire logic o_interrupt_out_first
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_b);
	logic setup;
	logic rd_acc;
	assign setup = i_psel && !i_penable && !i_pwrite;
	assign rd_acc = i_psel && i_penable && !i_pwrite;

	pready_const_a: assert property (o_pready)
		else $error("pready low");
	unmapped_err_a: assert property (setup && i_paddr == 8'hFC |=> o_pslverr)
		else $error("no error on unmapped read");
	err_zero_a: assert property (o_pslverr |-> o_prdata == 32'h0)
		else $error("refused read returned data");
	clear_self_a: assert property (
		setup && i_paddr == OFS_GENERAL_CONFIG |=> o_prdata == 32'h0)
		else $error("clear bit did not read back zero");
	status_clr_a: assert property (
		rd_acc && i_paddr == OFS_PRIMARY_STATUS |=> !o_interrupt_out_first)
		else $error("interrupt stayed up after status read");
	idle_high_a: assert property (
		$rose(i_rst_b) |-> (&o_energy_pulse_out_b) [*3])
		else $error("outputs not idle high after reset");
	irq_idle_a: assert property (
		$rose(i_rst_b) |-> (!o_interrupt_out_first) [*3])
		else $error("interrupt up after reset");
	low_hold_a: assert property (
		$fell(o_energy_pulse_out_b[0]) |=> (!o_energy_pulse_out_b[0]) [*8])
		else $error("output pulse too short");
	noload_fall_a: assert property (
		$fell(o_energy_pulse_out_b[0]) |-> !$past(i_no_load))
		else $error("output pulse started during no-load");

	fall_c: cover property ($fell(o_energy_pulse_out_b[0]));
	irq_c: cover property ($rose(o_interrupt_out_first));
	noload_c: cover property (i_no_load && !o_energy_pulse_out_b[0]);
endmodule : energy_pulse_monitor

bind energy_pulse_output_generator energy_pulse_monitor #(.N_OUT(N_OUT))
	mon_u (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_psel(i_psel),
	.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
	.o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
	.i_no_load(i_no_load), .o_energy_pulse_out_b(o_energy_pulse_out_b),
	.o_interrupt_out_first(o_interrupt_out_first));

// >>> tb/pulse_counter_model.sv
// External pulse counter: counts output pulses and measures low widths.
module pulse_counter_model (
	input wire logic i_clk,
	input wire logic [3:0] i_pulse_b,
	output int o_count [4],
	output int o_width [4]
);
	timeunit 1ns;
	timeprecision 1ps;
	int run [4];
	always @(posedge i_clk) begin
		for (int k = 0; k < 4; k++) begin
			if (i_pulse_b[k] === 1'b0) begin
				if (run[k] == 0) begin
					o_count[k] <= o_count[k] + 1;
				end
				run[k] <= run[k] + 1;
			end else begin
				if (run[k] != 0) begin
					o_width[k] <= run[k];
				end
				run[k] <= 0;
			end
		end
	end
endmodule : pulse_counter_model

// >>> tb/energy_pulse_output_generator_tb.sv
// Self-checking testbench of the energy pulse output generator.
module energy_pulse_output_generator_tb
	import pulse_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LONG = 200;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	power_bus_t power = '0;
	logic no_load = 1'b0;
	logic [3:0] pulse_b;
	logic irq;
	logic [31:0] q;
	int cnt [4];
	int wid [4];
	int failures = 0;
	int samples_checked = 0;

	energy_pulse_output_generator #(.N_OUT(4), .LONG_CYCLES(LONG)) dut_u (
		.i_clk(clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_power(power), .i_no_load(no_load),
		.o_energy_pulse_out_b(pulse_b), .o_interrupt_out_first(irq));
	pulse_counter_model cnt_u (.i_clk(clk), .i_pulse_b(pulse_b),
		.o_count(cnt), .o_width(wid));

	initial begin
		forever #10 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic end_of_test;
		$display("Compared %0d, mismatched %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_of_test

	task automatic give_up;
		failures++;
		end_of_test();
	endtask : give_up

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic chk_in(input int v, input int lo, input int hi);
		check(32'(v >= lo && v <= hi), 32'h1);
	endtask : chk_in

	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			give_up();
		end
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	task automatic wait_out(input logic lvl);
		int n;
		n = 0;
		while (pulse_b[0] !== lvl && n < 2000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 2000) begin
			give_up();
		end
	endtask : wait_out

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_regs;
		apb(0, OFS_THRESHOLD, 0);
		check(q, THRESHOLD_RST);
		apb(1, OFS_DIVIDER0, 32'h1);
		apb(0, OFS_DIVIDER0, 0);
		check(q, {16'h0, DIVIDER_RST});
		apb(1, OFS_DIVIDER0, 32'h2);
		apb(0, OFS_DIVIDER0, 0);
		check(q, 32'h2);
		apb(1, OFS_THRESHOLD, 32'h00100000);
		apb(0, OFS_THRESHOLD, 0);
		check(q, 32'h00100000);
		apb(0, OFS_WIDTH_TIMER, 0);
		check(q, {12'h0, WIDTH_TIMER_RST});
		apb(0, 8'hFC, 0);
		$display("Test regs done");
	endtask : t_regs

	task automatic t_rate;
		int c0;
		longint e;
		apb(1, OFS_THRESHOLD, 32'h1);
		apb(1, OFS_DIVIDER0, 32'h4);
		power[0] <= 32'd512;
		repeat (26) @(posedge clk);
		apb(1, OFS_GENERAL_CONFIG, 32'h1);
		apb(0, OFS_GENERAL_CONFIG, 0);
		check(q, 32'h0);
		c0 = cnt[0];
		repeat (30) @(posedge clk);
		check(cnt[0] - c0, 0);
		c0 = cnt[0];
		repeat (12500) @(posedge clk);
		e = 64'd12500 * DIGITAL_TO_FREQ_CONVERTER_KHZ * 512 / (1 * 512 * 4 * SYS_CLK_KHZ);
		chk_in(cnt[0] - c0, int'(e) - 1, int'(e) + 1);
		chk_in(wid[0], 23, 26);
		apb(1, OFS_DIVIDER0, 32'h5);
		repeat (300) @(posedge clk);
		chk_in(wid[0], 36, 39);
		$display("Test rate done");
	endtask : t_rate

	task automatic t_sign;
		int c0;
		power[0] <= 32'h0;
		repeat (220) @(posedge clk);
		apb(1, OFS_PULSE_MODE, 32'h1 << DIS_POS);
		apb(1, OFS_MASK, 32'h11);
		apb(0, OFS_PRIMARY_STATUS, 0);
		apb(0, OFS_EVENT_STATUS, 0);
		c0 = cnt[0];
		power[0] <= 32'hFFFFFE00;
		repeat (400) @(posedge clk);
		power[0] <= 32'h0;
		repeat (2) @(posedge clk);
		check(cnt[0] - c0, 0);
		check({31'h0, irq}, 32'h1);
		apb(0, OFS_PRIMARY_STATUS, 0);
		check(q, 32'h1 << SIGNCHG_POS);
		apb(0, OFS_EVENT_STATUS, 0);
		check(q, 32'h1);
		apb(0, OFS_SIGN_REPORT, 0);
		check(q, 32'h1);
		check({31'h0, irq}, 32'h0);
		apb(1, OFS_PULSE_MODE, 32'h0);
		$display("Test sign done");
	endtask : t_sign

	task automatic t_width;
		power[0] <= 32'd16;
		apb(1, OFS_DIVIDER0, 32'h2);
		repeat (2000) @(posedge clk);
		chk_in(wid[0], LONG - 1, LONG + 1);
		wait_out(1'b1);
		wait_out(1'b0);
		no_load <= 1'b1;
		repeat (LONG + 10) @(posedge clk);
		check({31'h0, pulse_b[0]}, 32'h1);
		no_load <= 1'b0;
		apb(1, OFS_WIDTH_TIMER, 32'h5);
		apb(1, OFS_WIDTH_CONFIG, 32'h1);
		repeat (2000) @(posedge clk);
		chk_in(wid[0], 55, 75);
		wait_out(1'b1);
		wait_out(1'b0);
		no_load <= 1'b1;
		repeat (300) @(posedge clk);
		check({31'h0, pulse_b[0]}, 32'h0);
		no_load <= 1'b0;
		repeat (100) @(posedge clk);
		check({31'h0, pulse_b[0]}, 32'h1);
		$display("Test width done");
	endtask : t_width

	task automatic t_select;
		int c0;
		power_bus_t v;
		apb(1, OFS_WIDTH_CONFIG, 32'h0);
		for (int t = 0; t < N_TYPE; t++) begin
			v = '0;
			v[t * N_PHASE + 1] = 32'd512;
			power <= v;
			apb(1, OFS_PULSE_MODE, 32'(t));
			for (int p = 0; p < 2; p++) begin
				apb(1, OFS_COMPUTATION_MODE, p ? 32'h5 : 32'h2);
				repeat (40) @(posedge clk);
				c0 = cnt[0];
				repeat (500) @(posedge clk);
				check(32'(cnt[0] - c0 > 10), 32'(p == 0));
			end
		end
		$display("Test select done");
	endtask : t_select

	initial begin
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		t_regs();
		t_rate();
		t_sign();
		t_width();
		t_select();
		end_of_test();
	end
endmodule : energy_pulse_output_generator_tb
